/* File: hw/ram_set_top.sv */
// Small, medium and large RAM blocks behind an AHB-Lite register slave
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module ram_set_top
  import ram_set_pkg::*;
(
  input wire logic hclk, // Bus clock, 20 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write transfer
  input wire logic [2:0] hsize, // Transfer size, word assumed
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp // Response, always OKAY
);
  // Bus phase tracking
  logic take;
  logic [7:0] addr_in;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [31:0] rd_mux;

  // Software registers
  logic [3:0] cmd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [BE_MAX-1:0] be_q;
  logic [DATA_MAX-1:0] wdata_q;
  logic [DATA_MAX-1:0] rdata_q;
  logic [3:0] mode_q;
  logic [29:0] pcfg_q;
  logic [N_PORT-1:0] clr_q;

  // Command state
  logic req_on;
  logic [2:0] req_port;
  logic req_we;
  logic busy;
  logic done;
  logic wr_cmd;
  logic [1:0] cmd_blk;
  logic [2:0] cmd_port;
  logic cmd_rom;
  logic cmd_go;
  logic finish;

  // Per-port results
  logic [N_PORT-1:0] p_taken;
  logic [N_PORT-1:0] p_rvalid;
  logic [N_PORT-1:0] p_wdone;
  logic [N_PORT-1:0] in_cap;
  logic [N_PORT-1:0] out_cap;
  logic [DATA_MAX-1:0] p_rdata [N_PORT];

  // Transfer accepted in its address phase
  assign take = hsel && hready && htrans[1];
  assign addr_in = (haddr[31:8] == 24'h000000) ? haddr[7:0] : OFF_NONE;

  // Address phase capture; reads take one wait state
  // Read data come from a register, so the slave stalls reads once;
  // writes land at the end of their data phase with no stall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
      hreadyout <= 1'b1;
    end else begin
      wr_pend <= take && hwrite;
      rd_pend <= take && !hwrite;
      hreadyout <= !(take && !hwrite);
      if (take && hwrite) begin
        wr_addr <= addr_in;
      end
      if (take && !hwrite) begin
        rd_addr <= addr_in;
      end
    end
  end

  // Read data and response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Register read decode; unmapped words read zero
  // The clear register is write-only and reads zero as well
  always_comb begin
    rd_mux = 32'h00000000;
    case (rd_addr)
      OFF_CMD: rd_mux = 32'(cmd_q);
      OFF_ADDR: rd_mux = 32'(addr_q);
      OFF_BE: rd_mux = 32'(be_q);
      OFF_WD0: rd_mux = wdata_q[31:0];
      OFF_WD1: rd_mux = wdata_q[63:32];
      OFF_WD2: rd_mux = 32'(wdata_q[71:64]);
      OFF_RD0: rd_mux = rdata_q[31:0];
      OFF_RD1: rd_mux = rdata_q[63:32];
      OFF_RD2: rd_mux = 32'(rdata_q[71:64]);
      OFF_STAT: rd_mux = 32'({done, busy});
      OFF_MODE: rd_mux = 32'(mode_q);
      OFF_PCFG: rd_mux = 32'(pcfg_q);
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Plain configuration and data registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
      be_q <= '0;
      wdata_q <= '0;
      mode_q <= MODE_RST;
      pcfg_q <= PCFG_RST;
    end else if (wr_pend) begin
      case (wr_addr)
        OFF_ADDR: addr_q <= hwdata[ADDR_W-1:0];
        OFF_BE: be_q <= hwdata[BE_MAX-1:0];
        OFF_WD0: wdata_q[31:0] <= hwdata;
        OFF_WD1: wdata_q[63:32] <= hwdata;
        OFF_WD2: wdata_q[71:64] <= hwdata[7:0];
        OFF_MODE: mode_q <= hwdata[3:0];
        OFF_PCFG: pcfg_q <= hwdata[29:0];
        default: mode_q <= mode_q;
      endcase
    end
  end

  // Output clear strobes from the fabric side, one cycle each
  // The clear is a pulse; it drops read data still waiting on a port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_q <= '0;
    end else if (wr_pend && wr_addr == OFF_CLR) begin
      clr_q <= hwdata[N_PORT-1:0];
    end else begin
      clr_q <= '0;
    end
  end

  // Command decode; the small block writes on A and reads on B
  // A command is ignored while busy or with the reserved block code,
  // so software must poll done before the next one
  always_comb begin
    wr_cmd = wr_pend && (wr_addr == OFF_CMD);
    cmd_blk = hwdata[CMD_BLK +: 2];
    cmd_port = {cmd_blk, hwdata[CMD_PORTB]};
    if (cmd_blk == 2'h0) begin
      cmd_port = {cmd_blk, !hwdata[CMD_WE]};
    end
    cmd_rom = 1'b0;
    if (cmd_blk == 2'h0) begin
      cmd_rom = hwdata[CMD_WE] && mode_q[MD_ROM0];
    end else if (cmd_blk == 2'h1) begin
      cmd_rom = hwdata[CMD_WE] && mode_q[MD_ROM0 + 1];
    end
    cmd_go = wr_cmd && !busy && (cmd_blk != BLK_BAD);
  end

  // An access ends when its port reports write or read done
  assign finish = busy && (p_wdone[req_port] || p_rvalid[req_port]);

  // Command, pending request and busy tracking
  // The request stays up until its port captures it on an enabled tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= 4'h0;
      req_on <= 1'b0;
      req_port <= 3'h0;
      req_we <= 1'b0;
      busy <= 1'b0;
    end else if (cmd_go) begin
      cmd_q <= hwdata[3:0];
      req_port <= cmd_port;
      req_we <= hwdata[CMD_WE];
      req_on <= !cmd_rom;
      busy <= !cmd_rom;
    end else begin
      if (req_on && p_taken[req_port]) begin
        req_on <= 1'b0;
      end
      if (finish) begin
        busy <= 1'b0;
      end
    end
  end

  // Sticky done; a completion beats a clearing write
  // so software never loses a completion that races its own clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done <= 1'b0;
    end else if (finish || (cmd_go && cmd_rom)) begin
      done <= 1'b1;
    end else if (wr_pend && wr_addr == OFF_STAT && hwdata[ST_DONE]) begin
      done <= 1'b0;
    end
  end

  // Read data land here when the active port delivers
  // and hold until the next read, as the bus may fetch them late
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else if (busy && p_rvalid[req_port]) begin
      rdata_q <= p_rdata[req_port];
    end
  end

  // Three blocks, two ports each
  // Depth follows from the bit count and the lane count of each block,
  // and each port keeps the location bits that its depth needs
  genvar b;
  genvar p;
  generate
    for (b = 0; b < N_BLK; b++) begin : g_blk
      localparam int W = BLK_LANES[b] * LANE_W;
      localparam int DEPTH = BLK_BITS[b] / W;
      localparam int AW = $clog2(DEPTH);
      wire [1:0] m_en;
      wire [1:0] m_we;
      wire [1:0][AW-1:0] m_addr;
      wire [1:0][BLK_LANES[b]-1:0] m_be;
      wire [1:0][W-1:0] m_wdata;
      wire [1:0][W-1:0] mem_q;

      // Storage; only the small and medium blocks preload
      ram_array #(
        .LANES(BLK_LANES[b]),
        .DEPTH(DEPTH),
        .AW(AW),
        .PRELOAD(BLK_PRELOAD[b])
      ) u_array (
        .hclk(hclk),
        .en(m_en),
        .we(m_we),
        .addr(m_addr),
        .be(m_be),
        .wdata(m_wdata),
        .q(mem_q)
      );

      for (p = 0; p < 2; p++) begin : g_port
        localparam int K = 2 * b + p;
        logic [W-1:0] rd_n;
        logic req_k;

        // Each register group runs on the clock it selects
        assign in_cap[K] = mode_q[MD_RUN0 + pcfg_q[K*PF_W+PF_ISEL]]
          && pcfg_q[K*PF_W+PF_CKEN];
        assign out_cap[K] = mode_q[MD_RUN0 + pcfg_q[K*PF_W+PF_OSEL]]
          && pcfg_q[K*PF_W+PF_CKEN];
        assign req_k = req_on && (req_port == 3'(K));
        assign p_rdata[K] = DATA_MAX'(rd_n);

        ram_port #(
          .LANES(BLK_LANES[b]),
          .AW(AW)
        ) u_port (
          .hclk(hclk),
          .hresetn(hresetn),
          .in_cap(in_cap[K]),
          .out_cap(out_cap[K]),
          .req(req_k),
          .req_we(req_we),
          .req_addr(addr_q),
          .req_be(be_q[BLK_LANES[b]-1:0]),
          .req_wdata(wdata_q[W-1:0]),
          .addr_ena(pcfg_q[K*PF_W+PF_AENA]),
          .bypass(pcfg_q[K*PF_W+PF_BYP]),
          .clr(clr_q[K]),
          .mem_q(mem_q[p]),
          .taken(p_taken[K]),
          .m_en(m_en[p]),
          .m_we(m_we[p]),
          .m_addr(m_addr[p]),
          .m_be(m_be[p]),
          .m_wdata(m_wdata[p]),
          .rdata(rd_n),
          .rvalid(p_rvalid[K]),
          .wdone(p_wdone[K])
        );
      end
    end
  endgenerate
endmodule

/* File: hw/ram_set_pkg.sv */
// Constants and register layout shared by the embedded RAM block set
// Overview of operation
// - Small block holds 576 bits, simple dual port
// - Small write side uses one selected clock
// - Small read and output clocks selectable
// - Small and medium blocks preload at configuration
// - Medium block holds 4608 bits, true dual port
// - Medium port registers on either clock
// - Ports A and B own enable, select, clear
// - Large block holds 589824 bits, RAM only
// - Large block has no preload, undefined
// - Large block inputs always registered
// - Large port 72 data, 8 lanes, 13-bit location
package ram_set_pkg;
  // Block geometry
  localparam int N_BLK = 3;
  localparam int N_PORT = 6;
  localparam int LANE_W = 9;
  localparam int DATA_MAX = 72;
  localparam int BE_MAX = 8;
  localparam int ADDR_W = 16;
  localparam int BLK_BITS [N_BLK] = '{576, 4608, 589824};
  localparam int BLK_LANES [N_BLK] = '{2, 4, 8};
  localparam bit BLK_PRELOAD [N_BLK] = '{1'b1, 1'b1, 1'b0};
  localparam int BLK_ROM [N_BLK] = '{1, 1, 0};

  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_BE = 8'h08;
  localparam logic [7:0] OFF_WD0 = 8'h0c;
  localparam logic [7:0] OFF_WD1 = 8'h10;
  localparam logic [7:0] OFF_WD2 = 8'h14;
  localparam logic [7:0] OFF_RD0 = 8'h18;
  localparam logic [7:0] OFF_RD1 = 8'h1c;
  localparam logic [7:0] OFF_RD2 = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h24;
  localparam logic [7:0] OFF_MODE = 8'h28;
  localparam logic [7:0] OFF_PCFG = 8'h2c;
  localparam logic [7:0] OFF_CLR = 8'h30;
  localparam logic [7:0] OFF_NONE = 8'hfc;

  // Command fields
  localparam int CMD_WE = 0;
  localparam int CMD_BLK = 1;
  localparam int CMD_PORTB = 3;
  localparam logic [1:0] BLK_BAD = 2'h3;

  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;

  // Mode fields
  localparam int MD_RUN0 = 0;
  localparam int MD_ROM0 = 2;

  // Per-port configuration fields, PF_W bits per port
  localparam int PF_W = 5;
  localparam int PF_CKEN = 0;
  localparam int PF_BYP = 1;
  localparam int PF_AENA = 2;
  localparam int PF_ISEL = 3;
  localparam int PF_OSEL = 4;

  // Values after reset
  localparam logic [3:0] MODE_RST = 4'h3;
  localparam logic [29:0] PCFG_RST = 30'h0a5294a5;
endpackage

/* File: hw/ram_array.sv */
// Two-port storage array with per-lane writes and registered reads
`timescale 1ns/1ps
module ram_array
  import ram_set_pkg::*;
#(
  parameter int LANES = 2,
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter bit PRELOAD = 1'b1,
  parameter logic [LANE_W-1:0] INIT_LANE = 9'h000
) (
  input wire logic hclk, // Clock
  input wire logic [1:0] en, // Access strobe per port
  input wire logic [1:0] we, // Write per port
  input wire logic [1:0][AW-1:0] addr, // Location per port
  input wire logic [1:0][LANES-1:0] be, // Lane enables per port
  input wire logic [1:0][LANES*LANE_W-1:0] wdata, // Write data per port
  output wire [1:0][LANES*LANE_W-1:0] q // Registered read data
);
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      // Preload at configuration where allowed, otherwise undefined
      logic [LANE_W-1:0] mem [DEPTH] =
        '{default: (PRELOAD ? INIT_LANE : 'x)};
      logic [LANE_W-1:0] qa;
      logic [LANE_W-1:0] qb;

      // Lane write, port B after port A on a shared location
      always_ff @(posedge hclk) begin
        if (en[0] && we[0] && be[0][l]) begin
          mem[addr[0]] <= wdata[0][l*LANE_W +: LANE_W];
        end
        if (en[1] && we[1] && be[1][l]) begin
          mem[addr[1]] <= wdata[1][l*LANE_W +: LANE_W];
        end
      end

      // Read registers hold until the next read
      always_ff @(posedge hclk) begin
        if (en[0] && !we[0]) begin
          qa <= mem[addr[0]];
        end
        if (en[1] && !we[1]) begin
          qb <= mem[addr[1]];
        end
      end

      assign q[0][l*LANE_W +: LANE_W] = qa;
      assign q[1][l*LANE_W +: LANE_W] = qb;
    end
  endgenerate
endmodule

/* File: hw/ram_port.sv */
// Port stage: input registers, read tracking and output register
`timescale 1ns/1ps
module ram_port
  import ram_set_pkg::*;
#(
  parameter int LANES = 2,
  parameter int AW = 5
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, active low
  input wire logic in_cap, // Input-side clock tick and enable
  input wire logic out_cap, // Output-side clock tick and enable
  input wire logic req, // Access waiting for this port
  input wire logic req_we, // Access is a write
  input wire logic [ADDR_W-1:0] req_addr, // Location
  input wire logic [LANES-1:0] req_be, // Lane enables
  input wire logic [LANES*LANE_W-1:0] req_wdata, // Write data
  input wire logic addr_ena, // Location register may load
  input wire logic bypass, // Skip output register
  input wire logic clr, // Clear output side
  input wire logic [LANES*LANE_W-1:0] mem_q, // Array read data
  output logic taken, // Access captured this cycle
  output logic m_en, // Array access strobe
  output logic m_we, // Array write
  output logic [AW-1:0] m_addr, // Array location
  output logic [LANES-1:0] m_be, // Array lane enables
  output logic [LANES*LANE_W-1:0] m_wdata, // Array write data
  output logic [LANES*LANE_W-1:0] rdata, // Read data
  output logic rvalid, // Read data ready, one cycle
  output logic wdone // Write finished, one cycle
);
  logic [ADDR_W-1:0] addr_q;
  logic [LANES*LANE_W-1:0] out_q;
  logic mem_v;
  logic out_v;

  // Access is captured only on an enabled input-side tick
  assign taken = req && in_cap;
  assign m_addr = addr_q[AW-1:0];
  assign rvalid = bypass ? mem_v : out_v;
  assign rdata = bypass ? mem_q : out_q;

  // Input registers; every input passes one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m_en <= 1'b0;
      m_we <= 1'b0;
      m_be <= '0;
      m_wdata <= '0;
      addr_q <= '0;
      wdone <= 1'b0;
    end else begin
      m_en <= taken;
      wdone <= m_en && m_we;
      if (taken) begin
        m_we <= req_we;
        m_be <= req_be;
        m_wdata <= req_wdata;
        if (addr_ena) begin
          addr_q <= req_addr;
        end
      end
    end
  end

  // Read data tracking and optional output register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_v <= 1'b0;
      out_v <= 1'b0;
      out_q <= '0;
    end else if (clr) begin
      mem_v <= 1'b0;
      out_v <= 1'b0;
      out_q <= '0;
    end else begin
      out_v <= 1'b0;
      if (m_en && !m_we) begin
        mem_v <= 1'b1;
      end else if (bypass || out_cap) begin
        mem_v <= 1'b0;
      end
      if (mem_v && out_cap && !bypass) begin
        out_q <= mem_q;
        out_v <= 1'b1;
      end
    end
  end
endmodule

/* File: verification/ram_set_props.sv */
// Bus-side checks of the RAM block set slave
`timescale 1ns/1ps
module ram_set_props
  import ram_set_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp // Response
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_ap;
  logic wr_ap;
  // Address phases taken by the slave
  assign rd_ap = hsel && hready && htrans[1] && !hwrite;
  assign wr_ap = hsel && hready && htrans[1] && hwrite;
  // Arguments are sampled, so the check sees the address phase itself
  function automatic logic at(input logic ap, input logic [31:0] a,
    input logic [7:0] o);
    return ap && a == {24'h0, o};
  endfunction
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("Response not OKAY");
  reset_idle_a: assert property (disable iff (1'b0)
    !hresetn |-> hreadyout && hrdata == 32'h0)
    else $error("Bus outputs not idle in reset");
  read_wait_a: assert property (rd_ap |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state wrong");
  write_fast_a: assert property (wr_ap |=> hreadyout)
    else $error("Write not zero wait");
  data_hold_a: assert property ($past(hreadyout) |-> $stable(hrdata))
    else $error("Read data moved without a read");
  unmapped_zero_a: assert property (
    rd_ap && haddr[31:8] != 24'h0 |-> ##2 hrdata == 32'h0)
    else $error("Unmapped read not zero");
  clear_zero_a: assert property (
    at(rd_ap, haddr, OFF_CLR) |-> ##2 hrdata == 32'h0)
    else $error("Clear register read not zero");
  addr_width_a: assert property (
    at(rd_ap, haddr, OFF_ADDR) |-> ##2 hrdata[31:16] == 0)
    else $error("Location wider than 16 bits");
  lane_width_a: assert property (
    at(rd_ap, haddr, OFF_BE) |-> ##2 hrdata[31:8] == 0)
    else $error("Lane enables wider than 8 bits");
  top_data_a: assert property (
    at(rd_ap, haddr, OFF_RD2) |-> ##2 hrdata[31:8] == 0)
    else $error("Top read word wider than 8 bits");
  pcfg_width_a: assert property (
    at(rd_ap, haddr, OFF_PCFG) |-> ##2 hrdata[31:30] == 0)
    else $error("Port config wider than 30 bits");
  cover property (rd_ap);
  cover property (wr_ap);
  cover property (rd_ap && haddr[31:8] != 24'h0);
endmodule
bind ram_set_top ram_set_props ram_set_props_inst (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

/* File: verification/fabric_master.sv */
// Bus master model standing for the fabric logic that drives the block
`timescale 1ns/1ps
module fabric_master (
  input wire logic hclk, // Clock
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output logic hsel, // Select
  output logic [31:0] haddr, // Address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write
  output logic [2:0] hsize, // Size
  output logic [31:0] hwdata // Write data
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Bounded wait for a rising edge with ready high
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 200);
    if (hready !== 1'b1) begin
      $display("Error at %0t: bus ready never came", $time);
      embedded_ram_block_set_bench.errors++;
      embedded_ram_block_set_bench.conclude();
    end
  endtask
  // Address phase held until taken, strobes driven by this side
  task automatic addr_phase(input logic [31:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
  endtask
  task automatic write_reg(input logic [31:0] a, input logic [31:0] d);
    addr_phase(a, 1'b1);
    hwdata <= d;
    wait_ready();
    hwdata <= ~d;
  endtask
  task automatic read_reg(input logic [31:0] a, output logic [31:0] d);
    addr_phase(a, 1'b0);
    wait_ready();
    d = hrdata;
  endtask
endmodule

/* File: verification/embedded_ram_block_set_bench.sv */
// Register-level bench for the RAM block set
`timescale 1ns/1ps
module embedded_ram_block_set_bench;
  import ram_set_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b1;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [71:0] q;
  logic [71:0] big;
  int errors = 0;
  int check_count = 0;
  ram_set_top ram_set_top_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  fabric_master fabric_master_inst (.hclk(hclk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // Clock of 50 ns
  initial begin
    forever #25 hclk = ~hclk;
  end
  task automatic conclude();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    fabric_master_inst.write_reg({24'h0, o}, d);
  endtask
  task automatic rd(input logic [7:0] o);
    fabric_master_inst.read_reg({24'h0, o}, rv);
  endtask
  // Location, lane enables and write data ahead of a command
  task automatic load(input logic [15:0] a, input logic [7:0] be,
                      input logic [71:0] d);
    wr(OFF_ADDR, {16'h0, a});
    wr(OFF_BE, {24'h0, be});
    wr(OFF_WD0, d[31:0]);
    wr(OFF_WD1, d[63:32]);
    wr(OFF_WD2, {24'h0, d[71:64]});
  endtask
  // Poll until done, then clear it
  task automatic wait_done();
    int n;
    n = 0;
    rv = 32'h0;
    while (rv[ST_DONE] !== 1'b1 && n < 40) begin
      rd(OFF_STAT);
      n++;
    end
    if (rv[ST_DONE] !== 1'b1) begin
      $display("Error at %0t: access never finished", $time);
      errors++;
      conclude();
    end
    wr(OFF_STAT, 32'h2);
  endtask
  task automatic run(input logic [3:0] cmd);
    wr(OFF_CMD, {28'h0, cmd});
    wait_done();
  endtask
  // Read one location and gather the wide result
  task automatic fetch(input logic [15:0] a, input logic [3:0] cmd);
    wr(OFF_ADDR, {16'h0, a});
    run(cmd);
    rd(OFF_RD0);
    q[31:0] = rv;
    rd(OFF_RD1);
    q[63:32] = rv;
    rd(OFF_RD2);
    q[71:64] = rv[7:0];
  endtask
  initial begin
    hresetn <= 1'b0;
    big = 72'hf1_2345_6789_abcd_ef01;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Values after reset and an unmapped place
    rd(OFF_MODE);
    chk({40'h0, rv}, {68'h0, MODE_RST});
    rd(OFF_PCFG);
    chk({40'h0, rv}, {42'h0, PCFG_RST});
    fabric_master_inst.read_reg(32'h100, rv);
    chk({40'h0, rv}, 72'h0);
    rd(OFF_CLR);
    chk({40'h0, rv}, 72'h0);
    // Small block: preload, last location, location wraps in 5 bits
    fetch(16'h0003, 4'h0);
    chk(q, 72'h0);
    load(16'h001f, 8'h03, 72'h3_5a5a);
    run(4'h1);
    fetch(16'hffff, 4'h0);
    chk(q, 72'h3_5a5a);
    // Small block in ROM mode ignores writes
    wr(OFF_MODE, 32'h7);
    load(16'h001f, 8'h03, 72'h1111);
    run(4'h1);
    wr(OFF_MODE, 32'h3);
    fetch(16'h001f, 4'h0);
    chk(q, 72'h3_5a5a);
    // Clock enable low holds the write until it returns
    load(16'h001f, 8'h03, 72'h2222);
    wr(OFF_PCFG, {2'h0, PCFG_RST & 30'h3ffffffe});
    wr(OFF_CMD, 32'h1);
    repeat (5) rd(OFF_STAT);
    chk({40'h0, rv}, 72'h1);
    wr(OFF_PCFG, {2'h0, PCFG_RST});
    wait_done();
    fetch(16'h001f, 4'h0);
    chk(q, 72'h2222);
    // Reserved block code is ignored
    wr(OFF_CMD, 32'h7);
    rd(OFF_STAT);
    chk({40'h0, rv}, 72'h0);
    // Medium block: one lane rewritten on A, read on B
    load(16'h007f, 8'h0f, 72'h9_8765_4321);
    run(4'h3);
    load(16'h007f, 8'h01, 72'h1aa);
    run(4'h3);
    fetch(16'h007f, 4'ha);
    chk(q, 72'h9_8765_43aa);
    // Large block: full write on A, top lane on B, bypassed read on A
    load(16'h1fff, 8'hff, big);
    run(4'h5);
    load(16'h1fff, 8'h80, {9'h0ab, 63'h0});
    run(4'hd);
    rd(OFF_ADDR);
    chk({40'h0, rv}, 72'h1fff);
    rd(OFF_BE);
    chk({40'h0, rv}, 72'h80);
    wr(OFF_PCFG, {2'h0, PCFG_RST | 30'h00200000});
    fetch(16'h1fff, 4'h4);
    chk(q, {9'h0ab, big[62:0]});
    // Output clear drops a read held at a stopped output clock
    wr(OFF_MODE, 32'h1);
    wr(OFF_PCFG, {2'h0, PCFG_RST | 30'h00000200});
    wr(OFF_CMD, 32'h0);
    rd(OFF_STAT);
    chk({40'h0, rv}, 72'h1);
    wr(OFF_CLR, 32'h3f);
    wr(OFF_MODE, 32'h3);
    repeat (3) rd(OFF_STAT);
    chk({40'h0, rv}, 72'h1);
    conclude();
  end
endmodule
